// >>> hw/amp_serial_ctrl.sv
// Serial control slave and mode logic of the stereo amplifier.
//
// Behaviour
// R1: address bit A1 follows address select pin
// R2: slave only, master clocks up to 400kHz
// R3: one combined selector/data byte, all acknowledged
// R4: selector 10 stores low five bits
// R5: coupling bit one selects capless mode
// R6: power enable bit turns device on
// R7: master opens with start condition
// R8: address MSB first, sampled on rising clock
// R9: master holds data stable while clock high
// R10: address acknowledged only on match
// R11: data byte receives second acknowledge
// R12: master closes with stop condition
// R13: speaker pairs switch at fixed 300kHz
// R14: idle outputs switch in phase, 50%
// R15: rising level widens positive, narrows negative
// R16: jack low enables speakers only
// R17: jack high enables headphones only
// R18: capacitor mode keeps sleeve bias off
// R19: sleeve short disables bias in capless
// R20: each volume is a 5-bit code
// R21: speaker code 0 -47dB, 31 30dB
// R22: headphone code 0 -59dB, 31 18dB
// R23: low speaker codes follow non-uniform ladder
`timescale 1ns/1ps
module amp_serial_ctrl #(
    parameter int level_width = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl_clock,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    input wire logic jack_sense_input,
    input wire logic sleeve_short_input,
    input wire logic signed [level_width-1:0] left_level,
    input wire logic signed [level_width-1:0] right_level,
    output logic power_enable,
    output logic capless_headphone_mode,
    output logic capacitor_coupled_mode,
    output logic [4:0] speaker_volume_code,
    output logic [4:0] headphone_volume_code,
    output logic signed [7:0] speaker_gain_half_db,
    output logic signed [7:0] headphone_gain_half_db,
    output logic speaker_enable,
    output logic headphone_enable,
    output logic sleeve_bias_amp,
    output logic left_speaker_pos,
    output logic left_speaker_neg,
    output logic right_speaker_pos,
    output logic right_speaker_neg
);
    typedef enum logic [2:0] {
        st_idle, st_addr, st_addr_ack, st_data, st_data_ack, st_ignore
    } link_state_e;

    // Link domain state, clocked by the master's serial clock.
    link_state_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] word_ff;
    logic word_tgl_ff;
    logic ack_ff;
    logic start_ff;
    logic stop_ff;
    logic start_seen;
    logic [7:0] nxt_shift;
    logic addr_match;
    logic [7:0] my_addr;

    // Start and stop are seen as data edges while the clock is high.
    // A start toggles start_ff on the falling data edge; the link logic
    // compares against its own copy so no signal has two drivers.
    always_ff @(negedge sda_in or negedge resetn) begin
        if (!resetn) begin
            start_ff <= 1'b0;
        end else if (scl_clock) begin
            start_ff <= ~start_ff; // [R7]
        end
    end

    always_ff @(posedge sda_in or negedge resetn) begin
        if (!resetn) begin
            stop_ff <= 1'b0;
        end else if (scl_clock) begin
            stop_ff <= ~stop_ff; // [R12]
        end
    end

    logic start_seen_ff;
    logic stop_seen_ff;
    logic stop_seen;
    assign start_seen = start_ff != start_seen_ff;
    assign stop_seen = stop_ff != stop_seen_ff;

    // The select pin is a free level; two serial clock rises settle it
    // long before the eighth address bit is compared.
    logic addr_pin_sync;
    sync_bit u_addr_sync (
        .clock(scl_clock),
        .resetn(resetn),
        .d(address_select_pin),
        .q(addr_pin_sync)
    );

    // Address: A1 comes from the select pin, all other bits fixed.
    assign my_addr = amp_ctrl_pkg::dev_addr_base
        | {6'h00, addr_pin_sync, 1'b0}; // [R1]
    assign nxt_shift = {shift_ff[6:0], sda_in}; // [R8]
    assign addr_match = nxt_shift == my_addr; // [R10]

    // Bits are taken on rising clock, MSB first; a start restarts.
    always_ff @(posedge scl_clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= st_idle;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            word_ff <= 8'h00;
            word_tgl_ff <= 1'b0;
            start_seen_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
        end else begin
            start_seen_ff <= start_ff;
            stop_seen_ff <= stop_ff;
            if (start_seen) begin
                state_ff <= st_addr;
                bit_cnt_ff <= 4'h1;
                shift_ff <= nxt_shift; // [R8]
            end else if (stop_seen) begin
                state_ff <= st_idle;
                bit_cnt_ff <= 4'h0;
            end else begin
                case (state_ff)
                    st_addr: begin
                        shift_ff <= nxt_shift;
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == 4'h7) begin
                            state_ff <= addr_match ? st_addr_ack
                                                   : st_ignore; // [R10]
                        end
                    end
                    st_addr_ack: begin
                        state_ff <= st_data;
                        bit_cnt_ff <= 4'h0;
                    end
                    st_data: begin
                        shift_ff <= nxt_shift;
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == 4'h7) begin
                            state_ff <= st_data_ack; // [R11]
                            word_ff <= nxt_shift; // [R3]
                            word_tgl_ff <= ~word_tgl_ff;
                        end
                    end
                    st_data_ack: state_ff <= st_ignore; // [R12]
                    st_idle: state_ff <= st_idle;
                    st_ignore: state_ff <= st_ignore;
                    default: state_ff <= st_idle;
                endcase
            end
        end
    end

    // The acknowledge is driven across the whole low/high/low of the
    // ninth clock, so it changes on falling edges only.
    always_ff @(negedge scl_clock or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (state_ff == st_addr_ack)
                || (state_ff == st_data_ack); // [R10] [R11]
        end
    end

    // Open-drain: only ever pulls low, never returns read data.
    assign sda_out = 1'b0; // [R2]
    assign sda_oe = ack_ff;

    // Core domain: the word crosses by toggle; the word is stable for
    // a whole byte time before the next toggle, far above two cycles.
    logic tgl_sync;
    logic tgl_seen_ff;
    logic jack_sync;
    logic short_sync;
    logic word_strobe;

    sync_bit u_tgl_sync (
        .clock(clock),
        .resetn(resetn),
        .d(word_tgl_ff),
        .q(tgl_sync)
    );
    sync_bit u_jack_sync (
        .clock(clock),
        .resetn(resetn),
        .d(jack_sense_input),
        .q(jack_sync)
    );
    sync_bit u_short_sync (
        .clock(clock),
        .resetn(resetn),
        .d(sleeve_short_input),
        .q(short_sync)
    );
    assign word_strobe = tgl_sync != tgl_seen_ff;

    // Register write decode on the selector bits.
    logic [1:0] sel;
    logic wr_shutdown;
    logic wr_hp_vol;
    logic wr_sp_vol;
    assign sel = word_ff[amp_ctrl_pkg::sel_hi:amp_ctrl_pkg::sel_lo];
    assign wr_shutdown = word_strobe && sel == amp_ctrl_pkg::sel_shutdown;
    assign wr_hp_vol = word_strobe
        && sel == amp_ctrl_pkg::sel_headphone_vol;
    assign wr_sp_vol = word_strobe
        && sel == amp_ctrl_pkg::sel_speaker_vol; // [R4]

    logic power_ff;
    logic coupling_ff;
    logic cc_ff;
    logic [4:0] sp_vol_ff;
    logic [4:0] hp_vol_ff;

    // Stored fields; bit 5 of a volume word is ignored.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tgl_seen_ff <= 1'b0;
            power_ff <= amp_ctrl_pkg::power_enable_rst;
            coupling_ff <= amp_ctrl_pkg::coupling_rst;
            cc_ff <= !amp_ctrl_pkg::coupling_rst;
            sp_vol_ff <= amp_ctrl_pkg::volume_rst;
            hp_vol_ff <= amp_ctrl_pkg::volume_rst;
        end else begin
            tgl_seen_ff <= tgl_sync;
            if (wr_shutdown) begin
                power_ff <= word_ff[amp_ctrl_pkg::power_enable_bit]; // [R6]
                coupling_ff <= word_ff[amp_ctrl_pkg::coupling_bit]; // [R5]
                cc_ff <= !word_ff[amp_ctrl_pkg::coupling_bit]; // [R5]
            end
            if (wr_sp_vol) begin
                sp_vol_ff <= word_ff[amp_ctrl_pkg::volume_hi:0]; // [R4]
            end
            if (wr_hp_vol) begin
                hp_vol_ff <= word_ff[amp_ctrl_pkg::volume_hi:0]; // [R20]
            end
        end
    end

    // Gain in half-dB steps; the low speaker codes use a fixed ladder.
    function automatic logic signed [7:0] sp_gain(input logic [4:0] c);
        logic signed [7:0] g;
        g = 8'sh00;
        case (c)
            5'h00: g = -8'sd94; // [R21]
            5'h01: g = -8'sd72; // [R23]
            5'h02: g = -8'sd57;
            5'h03: g = -8'sd45;
            5'h04: g = -8'sd36;
            5'h05: g = -8'sd30;
            5'h06: g = -8'sd24;
            5'h07: g = -8'sd18;
            5'h08: g = -8'sd12;
            5'h09: g = -8'sd6;
            default: g = 8'(3 * (int'(c) - 11)); // [R21] [R23]
        endcase
        return g;
    endfunction

    function automatic logic signed [7:0] hp_gain(input logic [4:0] c);
        logic signed [7:0] g;
        g = 8'sh00;
        case (c)
            5'h00: g = -8'sd118; // [R22]
            5'h01: g = -8'sd96;
            5'h02: g = -8'sd93;
            5'h03: g = -8'sd69;
            5'h04: g = -8'sd60;
            5'h05: g = -8'sd54;
            5'h06: g = -8'sd48;
            5'h07: g = -8'sd42;
            5'h08: g = -8'sd36;
            default: g = 8'(3 * (int'(c) - 19)); // [R22]
        endcase
        return g;
    endfunction

    // Output selection from jack sense, coupling and sleeve short.
    logic nxt_spk_en;
    logic nxt_hp_en;
    logic nxt_bias;
    assign nxt_spk_en = power_ff && !jack_sync; // [R16]
    assign nxt_hp_en = power_ff && jack_sync; // [R17]
    assign nxt_bias = nxt_hp_en && coupling_ff // [R18]
        && !short_sync; // [R19]

    logic spk_en_ff;
    logic hp_en_ff;
    logic bias_ff;
    logic signed [7:0] sp_gain_ff;
    logic signed [7:0] hp_gain_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            spk_en_ff <= 1'b0;
            hp_en_ff <= 1'b0;
            bias_ff <= 1'b0;
            sp_gain_ff <= 8'sh00;
            hp_gain_ff <= 8'sh00;
        end else begin
            spk_en_ff <= nxt_spk_en;
            hp_en_ff <= nxt_hp_en;
            bias_ff <= nxt_bias;
            sp_gain_ff <= sp_gain(sp_vol_ff);
            hp_gain_ff <= hp_gain(hp_vol_ff);
        end
    end

    // Pulse-width pairs, one per channel, at the fixed rate.
    pwm_pair #(
        .period(amp_ctrl_pkg::pwm_period_cycles),
        .half(amp_ctrl_pkg::pwm_half_cycles),
        .width(level_width)
    ) u_left (
        .clock(clock),
        .resetn(resetn),
        .enable(spk_en_ff),
        .level(left_level),
        .pos(left_speaker_pos), // [R13] [R14] [R15]
        .neg(left_speaker_neg)
    );
    pwm_pair #(
        .period(amp_ctrl_pkg::pwm_period_cycles),
        .half(amp_ctrl_pkg::pwm_half_cycles),
        .width(level_width)
    ) u_right (
        .clock(clock),
        .resetn(resetn),
        .enable(spk_en_ff),
        .level(right_level),
        .pos(right_speaker_pos), // [R13]
        .neg(right_speaker_neg)
    );

    assign power_enable = power_ff;
    assign capless_headphone_mode = coupling_ff; // [R5]
    assign capacitor_coupled_mode = cc_ff;
    assign speaker_volume_code = sp_vol_ff;
    assign headphone_volume_code = hp_vol_ff;
    assign speaker_gain_half_db = sp_gain_ff;
    assign headphone_gain_half_db = hp_gain_ff;
    assign speaker_enable = spk_en_ff;
    assign headphone_enable = hp_en_ff;
    assign sleeve_bias_amp = bias_ff;
endmodule

// >>> hw/amp_ctrl_pkg.sv
// Package of constants shared by the amplifier control block.
package amp_ctrl_pkg;
    // Device address with bit A1 taken from the address select pin.
    localparam logic [7:0] dev_addr_base = 8'hf8;
    localparam int addr_sel_bit = 1;
    // Register selector in the top two bits of the control word.
    localparam int sel_hi = 7;
    localparam int sel_lo = 6;
    localparam logic [1:0] sel_shutdown = 2'h0;
    localparam logic [1:0] sel_headphone_vol = 2'h1;
    localparam logic [1:0] sel_speaker_vol = 2'h2;
    // Field positions of the shutdown control register and the volume words.
    localparam int power_enable_bit = 0;
    localparam int coupling_bit = 1;
    localparam int volume_hi = 4;
    // Reset values; nothing is documented so the part comes up quiet.
    localparam logic power_enable_rst = 1'b0;
    localparam logic coupling_rst = 1'b0;
    localparam logic [4:0] volume_rst = 5'h00;
    // Switching rate of the speaker outputs and the core clock rate.
    localparam int pwm_rate_khz = 300;
    localparam int clock_rate_khz = 50000;
    localparam int pwm_period_cycles = clock_rate_khz / pwm_rate_khz;
    localparam int pwm_half_cycles = pwm_period_cycles / 2;
    // Highest master clock rate the slave supports.
    localparam int max_scl_rate_khz = 400;
endpackage

// >>> hw/sync_bit.sv
// Two flip-flop synchroniser for a single level.
`timescale 1ns/1ps
module sync_bit (
    input wire logic clock,
    input wire logic resetn,
    input wire logic d,
    output logic q
);
    logic meta_ff;
    logic q_ff;

    // The first stage is read only by the second stage.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

// >>> hw/pwm_pair.sv
// Differential pulse-width pair for one speaker channel.
`timescale 1ns/1ps
module pwm_pair #(
    parameter int period = 166,
    parameter int half = 83,
    parameter int width = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic signed [width-1:0] level,
    output logic pos,
    output logic neg
);
    logic [width:0] count_ff;
    logic pos_ff;
    logic neg_ff;
    logic signed [width+1:0] pos_th;
    logic signed [width+1:0] neg_th;
    logic signed [width+1:0] count_s;
    logic at_end;

    // Thresholds move apart with the level; zero gives equal halves.
    assign pos_th = (width+2)'(half) + (width+2)'(level);
    assign neg_th = (width+2)'(half) - (width+2)'(level);
    assign count_s = $signed({1'b0, count_ff});
    assign at_end = count_ff == (width+1)'(period - 1);

    // Both outputs rise together at the start of every period while the level lies strictly between minus half and plus half.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_ff <= '0;
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
        end else begin
            count_ff <= at_end ? '0 : count_ff + 1'b1;
            pos_ff <= enable && (count_s < pos_th);
            neg_ff <= enable && (count_s < neg_th);
        end
    end

    assign pos = pos_ff;
    assign neg = neg_ff;
endmodule

// >>> test/amp_serial_ctrl_props.sv
// Concurrent checks on the ports of the amplifier control block.
`timescale 1ns/1ps
module amp_serial_ctrl_props #(
    parameter int level_width = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl_clock,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic jack_sense_input,
    input wire logic sleeve_short_input,
    input wire logic signed [level_width-1:0] left_level,
    input wire logic capless_headphone_mode,
    input wire logic capacitor_coupled_mode,
    input wire logic [4:0] speaker_volume_code,
    input wire logic [4:0] headphone_volume_code,
    input wire logic signed [7:0] speaker_gain_half_db,
    input wire logic signed [7:0] headphone_gain_half_db,
    input wire logic speaker_enable,
    input wire logic headphone_enable,
    input wire logic sleeve_bias_amp,
    input wire logic left_speaker_pos,
    input wire logic left_speaker_neg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    localparam int sp_low [10] = '{-94, -72, -57, -45, -36, -30, -24, -18,
        -12, -6};
    localparam int hp_low [4] = '{-118, -96, -93, -69};
    logic [1:0] alive_ff;
    logic [7:0] idle_ff;
    logic [7:0] gap_ff;
    logic [7:0] seen_ff;

    // Gains in half decibels; the low codes sit on an uneven ladder.
    function automatic int sp_db(input logic [4:0] c);
        return (c < 10) ? sp_low[c] : 3 * int'(c) - 33;
    endfunction
    function automatic int hp_db(input logic [4:0] c);
        return (c < 4) ? hp_low[c] : (c < 10) ? 6 * int'(c) - 84
            : 3 * int'(c) - 57;
    endfunction

    // Time since reset, idle span, and spacing of pulse starts.
    // Spacing is judged only once level and enable held for a period,
    // since a change may start a pulse in the middle of a period.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            alive_ff <= 2'h0;
            idle_ff <= 8'h00;
            gap_ff <= 8'h00;
            seen_ff <= 8'h00;
        end else begin
            alive_ff <= {alive_ff[0], 1'b1};
            idle_ff <= (left_level != 0 || !speaker_enable) ? 8'h00
                : idle_ff + {7'h00, idle_ff != 8'hff};
            gap_ff <= $rose(left_speaker_pos) ? 8'h01
                : gap_ff + {7'h00, gap_ff != 8'hff};
            seen_ff <= (!speaker_enable || !$stable(left_level)) ? 8'h00
                : seen_ff + {7'h00, seen_ff != 8'hff};
        end
    end

    chk_hp_off_low: assert property (
        !jack_sense_input [*5] |-> !headphone_enable)
        else $error("headphones on with jack sense low");
    chk_spk_off_high: assert property (
        jack_sense_input [*5] |-> !speaker_enable)
        else $error("speakers on with jack sense high");
    chk_amp_exclusive: assert property (
        !(speaker_enable && headphone_enable))
        else $error("speakers and headphones on together");
    chk_mode_pair: assert property (
        capless_headphone_mode != capacitor_coupled_mode)
        else $error("coupling mode outputs disagree");
    chk_bias_coupled: assert property (
        capacitor_coupled_mode [*3] |-> !sleeve_bias_amp)
        else $error("sleeve bias on in coupled mode");
    chk_bias_short: assert property (
        sleeve_short_input [*5] |-> !sleeve_bias_amp)
        else $error("sleeve bias on while shorted");
    chk_pwm_idle: assert property (
        idle_ff > 8'haa |-> left_speaker_pos == left_speaker_neg)
        else $error("idle speaker pair not in phase");
    chk_pwm_quiet: assert property (
        !speaker_enable [*3] |-> !left_speaker_pos && !left_speaker_neg)
        else $error("speaker pair switching while disabled");
    chk_pwm_period: assert property (
        $rose(left_speaker_pos) && seen_ff > 8'hb0
        |-> gap_ff == 8'(amp_ctrl_pkg::pwm_period_cycles))
        else $error("speaker pulse period wrong");
    chk_ack_one_clock: assert property (
        @(negedge scl_clock) $rose(sda_oe) |=> !sda_oe)
        else $error("acknowledge held beyond one serial clock");
    chk_no_read_drive: assert property (
        sda_oe |-> !sda_out)
        else $error("data line driven high");
    chk_spk_gain: assert property (
        alive_ff[1] && $stable(speaker_volume_code)
        |-> int'(speaker_gain_half_db) == sp_db(speaker_volume_code))
        else $error("speaker gain does not match code");
    chk_hp_gain: assert property (
        alive_ff[1] && $stable(headphone_volume_code)
        |-> int'(headphone_gain_half_db) == hp_db(headphone_volume_code))
        else $error("headphone gain does not match code");
endmodule

// >>> test/serial_master.sv
// Behavioural two-wire master that writes one control byte per frame.
`timescale 1ns/1ps
module serial_master (
    output logic scl_clock,
    output logic sda_low,
    input wire logic sda
);
    // The clock stands high between frames and only toggles inside one.
    initial begin
        scl_clock = 1'b1;
        sda_low = 1'b0;
    end

    // Byte goes out MSB first, data settled before each rise.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = !b[i];
            #3.5 scl_clock = 1'b1;
            #7.5 scl_clock = 1'b0;
            #4;
        end
        sda_low = 1'b0;
        #3.5 scl_clock = 1'b1;
        ack = !sda;
        #7.5 scl_clock = 1'b0;
        #4;
    endtask

    // The word is sent even when refused, to show it is ignored.
    task automatic frame(input logic [7:0] addr, input logic [7:0] word,
                         output logic ack_a, output logic ack_d);
        sda_low = 1'b1;
        #4 scl_clock = 1'b0;
        #4;
        send_byte(addr, ack_a);
        send_byte(word, ack_d);
        sda_low = 1'b1;
        #3.5 scl_clock = 1'b1;
        #4 sda_low = 1'b0;
        #4;
    endtask
endmodule

// >>> test/audio_amp_serial_control_test.sv
// Self-checking bench for the amplifier serial control block.
`timescale 1ns/1ps
module audio_amp_serial_control_test;
    typedef struct packed {
        logic [7:0] word;
        logic [12:0] state;
    } row_s;
    localparam row_s rows [7] = '{
        '{8'h01, 13'h1400}, '{8'h03, 13'h1800}, '{8'hbf, 13'h1be0},
        '{8'h55, 13'h1bf5}, '{8'hc7, 13'h1bf5}, '{8'h02, 13'h0bf5},
        '{8'h01, 13'h17f5}};
    logic clock = 1'b0;
    logic resetn = 1'b1; // Falls at 1 ns so the idle serial side resets.
    logic address_select_pin = 1'b0;
    logic jack_sense_input = 1'b0;
    logic sleeve_short_input = 1'b0;
    logic signed [7:0] left_level = 8'sh00;
    logic signed [7:0] right_level = 8'sh00;
    logic scl_clock, sda_low, sda_out, sda_oe, power_enable;
    logic capless_headphone_mode, capacitor_coupled_mode;
    logic speaker_enable, headphone_enable, sleeve_bias_amp;
    logic left_speaker_pos, left_speaker_neg;
    logic right_speaker_pos, right_speaker_neg;
    logic [4:0] speaker_volume_code, headphone_volume_code;
    logic signed [7:0] speaker_gain_half_db, headphone_gain_half_db;
    logic [7:0] pos_n, neg_n, rp_n, rn_n;
    int errors = 0;
    int cmp_count = 0;
    // Pull-up on the data line; either party may only pull it low.
    wire sda = !(sda_low || (sda_oe && !sda_out));
    wire [12:0] state = {power_enable, capless_headphone_mode,
        capacitor_coupled_mode, speaker_volume_code, headphone_volume_code};
    wire [15:0] amps = {13'h0000, speaker_enable, headphone_enable,
        sleeve_bias_amp};

    amp_serial_ctrl #(.level_width(8)) dut (.*, .sda_in(sda));
    serial_master master (.*);

    always #10 clock = !clock;

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One framed write, then both acknowledge bits are compared.
    task automatic wr(input logic [7:0] addr, input logic [7:0] word,
                      input logic ok);
        logic ack_a;
        logic ack_d;
        master.frame(addr, word, ack_a, ack_d);
        repeat (10) @(negedge clock);
        check("address ack", 16'(ack_a), 16'(ok));
        check("data ack", 16'(ack_d), 16'(ok));
    endtask

    // Counting over one whole period makes the result phase-free.
    task automatic pwm(input logic signed [7:0] lvl);
        int h = amp_ctrl_pkg::pwm_half_cycles;
        left_level = lvl;
        right_level = -lvl;
        repeat (2 * amp_ctrl_pkg::pwm_period_cycles) @(negedge clock);
        pos_n = 8'h00;
        neg_n = 8'h00;
        rp_n = 8'h00;
        rn_n = 8'h00;
        repeat (amp_ctrl_pkg::pwm_period_cycles) begin
            @(negedge clock);
            pos_n += 8'(left_speaker_pos);
            neg_n += 8'(left_speaker_neg);
            rp_n += 8'(right_speaker_pos);
            rn_n += 8'(right_speaker_neg);
        end
        check("pos", 16'(pos_n), 16'(h + lvl));
        check("neg", 16'(neg_n), 16'(h - lvl));
        check("right pos", 16'(rp_n), 16'(h - lvl));
        check("right neg", 16'(rn_n), 16'(h + lvl));
    endtask

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        #1 resetn = 1'b0;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        check("reset state", 16'(state), 16'h0400);
        check("reset amps", amps, 16'h0000);
        foreach (rows[i]) begin
            wr(8'hf8, rows[i].word, 1'b1);
            check("state", 16'(state), 16'(rows[i].state));
        end
        address_select_pin = 1'b1;
        wr(8'hf8, 8'h00, 1'b0);
        check("refused write", 16'(state), 16'h17f5);
        wr(8'hfa, 8'h8b, 1'b1);
        check("moved address", 16'(state), 16'h1575);
        address_select_pin = 1'b0;
        for (int c = 0; c < 32; c++) begin
            wr(8'hf8, 8'h80 | 8'(c), 1'b1);
            wr(8'hf8, 8'h40 | 8'(c), 1'b1);
            check("volume codes", 16'({speaker_volume_code,
                headphone_volume_code}), 16'({5'(c), 5'(c)}));
        end
        wr(8'hf8, 8'h03, 1'b1);
        check("speaker mode", amps, 16'h0004);
        jack_sense_input = 1'b1;
        repeat (10) @(negedge clock);
        check("headphone mode", amps, 16'h0003);
        sleeve_short_input = 1'b1;
        repeat (10) @(negedge clock);
        check("sleeve short", amps, 16'h0002);
        sleeve_short_input = 1'b0;
        wr(8'hf8, 8'h01, 1'b1);
        check("coupled mode", amps, 16'h0002);
        jack_sense_input = 1'b0;
        repeat (10) @(negedge clock);
        pwm(8'sh00);
        pwm(8'sh28);
        pwm(-8'sh28);
        // A reset in mid-run must clear both domains and allow a new frame.
        resetn = 1'b0;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        check("mid reset", 16'(state), 16'h0400);
        wr(8'hf8, 8'h01, 1'b1);
        check("after reset", 16'(state), 16'h1400);
        conclude();
    end

    // Cut a hang short well past the expected run length.
    initial begin
        #400us;
        errors++;
        conclude();
    end
endmodule

bind amp_serial_ctrl amp_serial_ctrl_props #(.level_width(level_width))
    props (.*);
